// >>> mmsd_consts.svh
`ifndef MMSD_CONSTS_SVH
`define MMSD_CONSTS_SVH

// Internal space layout
`define MMSD_HALF_BIT        7
`define MMSD_BIT_BYTE_BASE   4'h2
`define MMSD_SFS_BIT_LOW     3'h0

// External data mapping choices
`define MMSD_XMAP_ONCHIP     2'h0
`define MMSD_XMAP_SPLIT      2'h1
`define MMSD_XMAP_OFFCHIP    2'h2

// External data split point and alias width
`define MMSD_XRAM_AW         12
`define MMSD_XRAM_SPLIT      16'h1000

// Program flash layout
`define MMSD_FLASH_TOP       17'h0FFFF
`define MMSD_FACTORY_BASE    17'h0FE00
`define MMSD_TBL_BASE        17'h10000
`define MMSD_TBL_LAST        17'h1007F
`define MMSD_SECTOR_LSB      9

`endif

// >>> mmsd_pkg.sv
package mmsd_pkg;

    // Kind of access issued by the core
    typedef enum logic [2:0] {
        MMSD_SP_DIRECT   = 3'h0,
        MMSD_SP_INDIRECT = 3'h1,
        MMSD_SP_REG      = 3'h2,
        MMSD_SP_BIT      = 3'h3,
        MMSD_SP_XDATA    = 3'h4,
        MMSD_SP_CODE     = 3'h5
    } mmsd_space_t;

    // Whole registered state of the decoder
    typedef struct packed {
        logic        resp_valid;
        logic        wr;
        logic        sel_iram;
        logic        sel_sfs;
        logic [7:0]  iram_addr;
        logic        bit_op;
        logic [2:0]  bit_idx;
        logic        sel_xram;
        logic [11:0] xram_addr;
        logic        sel_offchip;
        logic [15:0] offchip_addr;
        logic        offchip_muxed;
        logic        sel_flash;
        logic        sel_flash_tbl;
        logic [15:0] flash_addr;
        logic [6:0]  flash_sector;
        logic        flash_factory;
        logic        wr_refused;
        logic        unmapped;
    } mmsd_state_t;

endpackage : mmsd_pkg

// >>> mmsd_decoder.sv
`timescale 1ns/1ps
`include "mmsd_consts.svh"
// Behaviour
// - Indirect upper half reaches upper scratch RAM
// - Direct upper half reaches special function space
// - Lower half shared by direct and indirect
// - First 32 bytes form four register banks
// - Next 16 bytes byte and bit addressable
// - On-chip 4 KB aliased over 64 KB
// - On-chip, off-chip or split at 4 KB
// - Off-chip port multiplexed or separate lines
// - 64 KB flash in 512-byte sectors
// - Factory region 0xFE00-0xFFFF never written
// - Extra 128-byte flash sector at 0x10000
module mmsd_decoder
    import mmsd_pkg::*;
#(
    parameter int XRAM_AW = `MMSD_XRAM_AW
) (
    // Clock, reset, enable
    input  logic        clk,
    input  logic        sys_rst,
    input  logic        clk_en,
    // Core request
    input  logic        req_valid,
    input  mmsd_space_t req_space,
    input  logic [16:0] req_addr,
    input  logic        req_write,
    input  logic [1:0]  bank_sel,
    // Configuration settings
    input  logic [1:0]  cfg_xmap,
    input  logic        cfg_mux,
    // Answer strobe and faults
    output logic        resp_valid,
    output logic        resp_write,
    output logic        wr_refused,
    output logic        unmapped,
    // Internal RAM and special function space
    output logic        sel_iram,
    output logic        sel_sfs,
    output logic [7:0]  iram_addr,
    output logic        bit_op,
    output logic [2:0]  bit_idx,
    // External data targets
    output logic        sel_xram,
    output logic [11:0] xram_addr,
    output logic        sel_offchip,
    output logic [15:0] offchip_addr,
    output logic        offchip_muxed,
    // Program flash
    output logic        sel_flash,
    output logic        sel_flash_tbl,
    output logic [15:0] flash_addr,
    output logic [6:0]  flash_sector,
    output logic        flash_factory
);

    // Only the documented on-chip RAM width is served
    if (XRAM_AW != `MMSD_XRAM_AW) begin : g_bad_aw
        $error("XRAM_AW must equal the on-chip RAM width");
    end

    mmsd_state_t st;       // Registered state
    mmsd_state_t next_st;  // Next state

    logic [7:0]  a8;       // Internal address byte
    logic [15:0] a16;      // External address

    assign a8  = req_addr[7:0];
    assign a16 = req_addr[15:0];

    // Decode one request into target selects
    always_comb begin
        next_st            = st;
        next_st.resp_valid = 1'b0;
        if (req_valid) begin
            next_st               = '0;
            next_st.resp_valid    = 1'b1;
            next_st.wr            = req_write;
            next_st.offchip_muxed = st.offchip_muxed;
            case (req_space)
                // Direct: upper half is the register space
                MMSD_SP_DIRECT: begin
                    next_st.iram_addr = a8;
                    if (a8[`MMSD_HALF_BIT]) begin
                        next_st.sel_sfs = 1'b1;
                    end else begin
                        next_st.sel_iram = 1'b1;
                    end
                end
                // Indirect: all 256 bytes are RAM
                MMSD_SP_INDIRECT: begin
                    next_st.iram_addr = a8;
                    next_st.sel_iram  = 1'b1;
                end
                // Working register in the chosen bank
                MMSD_SP_REG: begin
                    next_st.iram_addr = {3'h0, bank_sel, a8[2:0]};
                    next_st.sel_iram  = 1'b1;
                end
                // Single bit access
                MMSD_SP_BIT: begin
                    next_st.bit_op  = 1'b1;
                    next_st.bit_idx = a8[2:0];
                    if (a8[`MMSD_HALF_BIT]) begin
                        // Bit-addressable register bytes
                        next_st.sel_sfs   = 1'b1;
                        next_st.iram_addr = {a8[7:3], `MMSD_SFS_BIT_LOW};
                    end else begin
                        // Bytes after the register banks
                        next_st.sel_iram  = 1'b1;
                        next_st.iram_addr = {`MMSD_BIT_BYTE_BASE, a8[6:3]};
                    end
                end
                // External data, settings taken now
                MMSD_SP_XDATA: begin
                    next_st.offchip_muxed = cfg_mux;
                    next_st.xram_addr     = a16[11:0];
                    next_st.offchip_addr  = a16;
                    case (cfg_xmap)
                        `MMSD_XMAP_ONCHIP: begin
                            next_st.sel_xram = 1'b1;
                        end
                        `MMSD_XMAP_SPLIT: begin
                            if (a16 < `MMSD_XRAM_SPLIT) begin
                                next_st.sel_xram = 1'b1;
                            end else begin
                                next_st.sel_offchip = 1'b1;
                            end
                        end
                        default: begin
                            next_st.sel_offchip = 1'b1;
                        end
                    endcase
                end
                // Program memory, main array or table sector
                MMSD_SP_CODE: begin
                    next_st.flash_addr = a16;
                    if (req_addr <= `MMSD_FLASH_TOP) begin
                        next_st.flash_sector =
                            a16[15:`MMSD_SECTOR_LSB];
                        next_st.flash_factory =
                            (req_addr >= `MMSD_FACTORY_BASE);
                        if (req_write &&
                            req_addr >= `MMSD_FACTORY_BASE) begin
                            next_st.wr_refused = 1'b1;
                        end else begin
                            next_st.sel_flash = 1'b1;
                        end
                    end else if (req_addr <= `MMSD_TBL_LAST) begin
                        next_st.sel_flash_tbl = 1'b1;
                    end else begin
                        next_st.unmapped = 1'b1;
                    end
                end
                // Unknown kinds select nothing
                default: begin
                    next_st.unmapped = 1'b1;
                end
            endcase
        end
    end

    // State register; reset clears it, else it is frozen while the enable is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign resp_valid    = st.resp_valid;
    assign resp_write    = st.wr;
    assign wr_refused    = st.wr_refused;
    assign unmapped      = st.unmapped;
    assign sel_iram      = st.sel_iram;
    assign sel_sfs       = st.sel_sfs;
    assign iram_addr     = st.iram_addr;
    assign bit_op        = st.bit_op;
    assign bit_idx       = st.bit_idx;
    assign sel_xram      = st.sel_xram;
    assign xram_addr     = st.xram_addr;
    assign sel_offchip   = st.sel_offchip;
    assign offchip_addr  = st.offchip_addr;
    assign offchip_muxed = st.offchip_muxed;
    assign sel_flash     = st.sel_flash;
    assign sel_flash_tbl = st.sel_flash_tbl;
    assign flash_addr    = st.flash_addr;
    assign flash_sector  = st.flash_sector;
    assign flash_factory = st.flash_factory;

    // Request taken on this edge
    logic take;
    assign take = req_valid && clk_en && !sys_rst;

    // Checks on the decode
    property p_ind_hi;
        @(posedge clk) disable iff (sys_rst)
        take && req_space == MMSD_SP_INDIRECT && a8[7]
        |=> sel_iram && !sel_sfs && iram_addr == $past(a8);
    endproperty
    a_ind_hi: assert property (p_ind_hi)
        else $error("indirect upper access missed scratch RAM");

    property p_dir_hi;
        @(posedge clk) disable iff (sys_rst)
        take && req_space == MMSD_SP_DIRECT && a8[7]
        |=> sel_sfs && !sel_iram;
    endproperty
    a_dir_hi: assert property (p_dir_hi)
        else $error("direct upper access missed register space");

    property p_lo_shared;
        @(posedge clk) disable iff (sys_rst)
        take && !a8[7] && (req_space == MMSD_SP_DIRECT ||
                           req_space == MMSD_SP_INDIRECT)
        |=> sel_iram && iram_addr == $past(a8);
    endproperty
    a_lo_shared: assert property (p_lo_shared)
        else $error("lower RAM not shared");

    property p_bank;
        @(posedge clk) disable iff (sys_rst)
        take && req_space == MMSD_SP_REG
        |=> iram_addr < 8'h20 && iram_addr[4:3] == $past(bank_sel);
    endproperty
    a_bank: assert property (p_bank)
        else $error("register bank address wrong");

    property p_bitram;
        @(posedge clk) disable iff (sys_rst)
        take && req_space == MMSD_SP_BIT && !a8[7]
        |=> bit_op && iram_addr >= 8'h20 && iram_addr < 8'h30;
    endproperty
    a_bitram: assert property (p_bitram)
        else $error("bit address outside bit area");

    property p_alias;
        @(posedge clk) disable iff (sys_rst)
        take && req_space == MMSD_SP_XDATA && cfg_xmap == 2'h0
        |=> sel_xram && !sel_offchip && xram_addr == $past(a16[11:0]);
    endproperty
    a_alias: assert property (p_alias)
        else $error("on-chip RAM not aliased");

    property p_split;
        @(posedge clk) disable iff (sys_rst)
        take && req_space == MMSD_SP_XDATA && cfg_xmap == 2'h1
        |=> (sel_offchip == ($past(a16) >= 16'h1000)) &&
            (sel_xram != sel_offchip);
    endproperty
    a_split: assert property (p_split)
        else $error("split mapping wrong");

    property p_mux;
        @(posedge clk) disable iff (sys_rst)
        take && req_space == MMSD_SP_XDATA
        |=> offchip_muxed == $past(cfg_mux);
    endproperty
    a_mux: assert property (p_mux)
        else $error("port multiplexing setting not sampled");

    property p_factory;
        @(posedge clk) disable iff (sys_rst)
        take && req_space == MMSD_SP_CODE && req_write &&
        req_addr >= 17'h0FE00 && req_addr <= 17'h0FFFF
        |=> wr_refused && !sel_flash;
    endproperty
    a_factory: assert property (p_factory)
        else $error("factory region write not refused");

    property p_tbl;
        @(posedge clk) disable iff (sys_rst)
        take && req_space == MMSD_SP_CODE && req_addr[16]
        |=> sel_flash_tbl == ($past(req_addr) <= 17'h1007F) && !sel_flash;
    endproperty
    a_tbl: assert property (p_tbl)
        else $error("table sector decode wrong");

    property p_sector;
        @(posedge clk) disable iff (sys_rst)
        take && req_space == MMSD_SP_CODE && !req_addr[16]
        |=> flash_sector == $past(req_addr[15:9]);
    endproperty
    a_sector: assert property (p_sector)
        else $error("flash sector index wrong");

    // Main scenarios
    c_sfs: cover property (@(posedge clk) take ##1 sel_sfs);
    c_split_off: cover property (@(posedge clk)
        take && cfg_xmap == 2'h1 ##1 sel_offchip);
    c_tbl: cover property (@(posedge clk) take ##1 sel_flash_tbl);
    c_refused: cover property (@(posedge clk) take ##1 wr_refused);

endmodule : mmsd_decoder

// >>> mmsd_core_model.sv
`timescale 1ns/1ps
module mmsd_core_model
    import mmsd_pkg::*;
(
    // Clock
    input  logic        clk,
    // Request toward the decoder
    output logic        req_valid,
    output mmsd_space_t req_space,
    output logic [16:0] req_addr,
    output logic        req_write
);
    // Quiet request lines at time zero
    initial begin
        req_valid = 1'h0;
        req_space = MMSD_SP_DIRECT;
        req_addr  = 17'h00000;
        req_write = 1'h0;
    end

    // Present one request and hold it over one edge; call just after an edge
    task automatic issue(input mmsd_space_t sp, input logic [16:0] a,
                         input logic w);
        req_valid = 1'h1;
        req_space = sp;
        req_addr  = a;
        req_write = w;
        @(posedge clk);
        #1;
    endtask : issue

    // Drop the request; stale address inverted so it cannot pass as valid
    task automatic idle();
        req_valid = 1'h0;
        req_addr  = ~req_addr;
        req_write = ~req_write;
        @(posedge clk);
        #1;
    endtask : idle
endmodule : mmsd_core_model

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top
    import mmsd_pkg::*;
;
    // Bench state
    logic clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1;
    logic [1:0] bank_sel = 2'h0, cfg_xmap = 2'h0;
    logic cfg_mux = 1'h0, req_valid, req_write;
    mmsd_space_t req_space;
    logic [16:0] req_addr;
    logic resp_valid, resp_write, wr_refused, unmapped, sel_iram, sel_sfs;
    logic bit_op, sel_xram, sel_offchip, offchip_muxed, sel_flash;
    logic sel_flash_tbl, flash_factory;
    logic [7:0] iram_addr;
    logic [2:0] bit_idx;
    logic [11:0] xram_addr;
    logic [15:0] offchip_addr, flash_addr;
    logic [6:0] flash_sector;
    int errors = 0, cmp_count = 0;
    // External data table: map, mux, address, on-chip (else off-chip)
    logic [1:0]  xm[5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic        xx[5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
    logic [15:0] xa[5] = '{16'hF234, 16'h0FFF, 16'h1000, 16'h0010, 16'h8010};
    logic        xs[5] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0};

    // 100 MHz clock
    always #5 clk = ~clk;

    mmsd_core_model u_core (.clk(clk), .req_valid(req_valid),
        .req_space(req_space), .req_addr(req_addr), .req_write(req_write));

    mmsd_decoder DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .req_valid(req_valid), .req_space(req_space), .req_addr(req_addr),
        .req_write(req_write), .bank_sel(bank_sel), .cfg_xmap(cfg_xmap),
        .cfg_mux(cfg_mux), .resp_valid(resp_valid), .resp_write(resp_write),
        .wr_refused(wr_refused), .unmapped(unmapped), .sel_iram(sel_iram),
        .sel_sfs(sel_sfs), .iram_addr(iram_addr), .bit_op(bit_op),
        .bit_idx(bit_idx), .sel_xram(sel_xram), .xram_addr(xram_addr),
        .sel_offchip(sel_offchip), .offchip_addr(offchip_addr),
        .offchip_muxed(offchip_muxed), .sel_flash(sel_flash),
        .sel_flash_tbl(sel_flash_tbl), .flash_addr(flash_addr),
        .flash_sector(flash_sector), .flash_factory(flash_factory));

    // Request with answer strobe check
    task automatic go(input mmsd_space_t sp, input logic [16:0] a,
                      input logic w);
        u_core.issue(sp, a, w);
        `CHK(resp_valid, 1'h1)
        `CHK(resp_write, w)
    endtask : go

    // Direct and indirect internal accesses, back to back
    task automatic t_iram();
        go(MMSD_SP_DIRECT, 17'h00090, 1'h0);
        `CHK({sel_sfs, sel_iram, iram_addr}, 10'h290)
        go(MMSD_SP_INDIRECT, 17'h00090, 1'h1);
        `CHK({sel_sfs, sel_iram, iram_addr}, 10'h190)
        go(MMSD_SP_DIRECT, 17'h0007F, 1'h0);
        `CHK({sel_sfs, sel_iram, iram_addr}, 10'h17F)
        go(MMSD_SP_INDIRECT, 17'h0007F, 1'h0);
        `CHK({sel_sfs, sel_iram, iram_addr}, 10'h17F)
        u_core.idle();
        `CHK({resp_valid, iram_addr}, 9'h07F)
    endtask : t_iram

    // Every register bank
    task automatic t_bank();
        for (int b = 0; b < 4; b++) begin
            bank_sel = b[1:0];
            go(MMSD_SP_REG, 17'h00005, 1'h0);
            `CHK(iram_addr, {3'h0, b[1:0], 3'h5})
        end
    endtask : t_bank

    // Bit area top edge and register space bits
    task automatic t_bit();
        go(MMSD_SP_BIT, 17'h0000B, 1'h0);
        `CHK({bit_op, iram_addr, bit_idx}, 12'h90B)
        go(MMSD_SP_BIT, 17'h0007F, 1'h1);
        `CHK({bit_op, iram_addr, bit_idx}, 12'h97F)
        go(MMSD_SP_BIT, 17'h0008B, 1'h0);
        `CHK({sel_sfs, iram_addr, bit_idx}, 12'hC43)
    endtask : t_bit

    // External data mapping choices and port mode
    task automatic t_xdata();
        for (int i = 0; i < 5; i++) begin
            cfg_xmap = xm[i];
            cfg_mux  = xx[i];
            go(MMSD_SP_XDATA, {1'h0, xa[i]}, 1'h0);
            `CHK({sel_xram, sel_offchip}, {xs[i], ~xs[i]})
            if (xs[i]) begin
                `CHK(xram_addr, xa[i][11:0])
            end else begin
                `CHK(offchip_addr, xa[i])
            end
            `CHK(offchip_muxed, xx[i])
        end
        cfg_mux = 1'h1;
        go(MMSD_SP_DIRECT, 17'h00010, 1'h0);
        `CHK({offchip_muxed, sel_offchip}, 2'h0)
    endtask : t_xdata

    // Flash sectors, factory region, table sector, unmapped space
    task automatic t_code();
        go(MMSD_SP_CODE, 17'h003FF, 1'h1);
        `CHK({sel_flash, flash_sector, flash_addr}, 24'h8103FF)
        go(MMSD_SP_CODE, 17'h0FFFF, 1'h0);
        `CHK({sel_flash, flash_factory}, 2'h3)
        go(MMSD_SP_CODE, 17'h0FE00, 1'h1);
        `CHK({wr_refused, sel_flash, flash_factory}, 3'h5)
        go(MMSD_SP_CODE, 17'h1007F, 1'h0);
        `CHK({sel_flash_tbl, flash_addr[6:0]}, 8'hFF)
        go(MMSD_SP_CODE, 17'h10080, 1'h0);
        `CHK({unmapped, sel_flash_tbl, sel_flash}, 3'h4)
        go(mmsd_space_t'(3'h6), 17'h00000, 1'h0);
        `CHK({unmapped, sel_iram, sel_sfs, sel_flash}, 4'h8)
        u_core.idle();
    endtask : t_code

    // Clock enable freezes state; reset in mid-run clears it
    task automatic t_hold();
        clk_en = 1'h0;
        u_core.issue(MMSD_SP_DIRECT, 17'h00090, 1'h0);
        `CHK({sel_sfs, unmapped}, 2'h1)
        clk_en = 1'h1;
        go(MMSD_SP_DIRECT, 17'h00090, 1'h0);
        `CHK(sel_sfs, 1'h1)
        sys_rst = 1'h1;
        u_core.idle();
        `CHK({sel_sfs, iram_addr}, 9'h000)
        sys_rst = 1'h0;
        go(MMSD_SP_INDIRECT, 17'h000A5, 1'h0);
        `CHK({sel_sfs, sel_iram, iram_addr}, 10'h1A5)
    endtask : t_hold

    // Counts, verdict, stop
    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'h0;
        @(posedge clk);
        #1;
        `CHK({resp_valid, sel_iram, sel_flash}, 3'h0)
        t_iram();
        t_bank();
        t_bit();
        t_xdata();
        t_code();
        t_hold();
        end_of_test();
    end

    // Hang guard, far beyond the some 40 cycles needed
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
endmodule : tb_top
